/* File: bench/tb_top.sv */
// self-checking testbench for the watchdog timer block
`timescale 1ns/1ns
module tb_top;
  import wdt_pkg::*;
  // --------------------------------------------------------------
  // clock, reset and design
  // --------------------------------------------------------------
  localparam int STEP = 10;
  localparam int PULSE = 8;
  logic clk;
  logic rstn;
  wdt_io_t io;
  logic sys_reset_q;
  logic armed_q;
  logic [3:0] steps_q;
  int failures;
  int comparisons;
  int n;

  wdt_top #(.STEP_CYCLES(STEP), .PULSE_CYCLES(PULSE)) i_wdt_top (
    .clk(clk),
    .rstn(rstn),
    .io(io),
    .sys_reset_q(sys_reset_q),
    .armed_q(armed_q),
    .steps_q(steps_q)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_in(input string what, input int lo, input int hi,
                        input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      failures++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_in

  task automatic io_write(input logic [15:0] addr, input logic [15:0] data);
    @(negedge clk);
    io = '{wr: 1'b1, addr: addr, data: data};
    @(negedge clk);
    io.wr = 1'b0;
  endtask : io_write

  // cycles until the system reset shows, or until it falls
  task automatic wait_level(input logic lvl, output int cnt);
    cnt = 0;
    while (sys_reset_q !== lvl && cnt < 1000) begin
      @(negedge clk);
      cnt++;
    end
  endtask : wait_level

  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_fire_now;
    chk("armed after reset", 16'h0, armed_q);
    chk("sysrst after reset", 16'h0, sys_reset_q);
    io_write(WDT_ENABLE_ADDR, 16'h000f);
    chk("armed", 16'h1, armed_q);
    chk("steps code f", 16'h0, steps_q);
    wait_level(1'b1, n);
    chk_in("fire delay code f", 1, 1, n);
    wait_level(1'b0, n);
    chk_in("pulse length", PULSE, PULSE, n);
    chk("armed after fire", 16'h0, armed_q);
    $display("test fire_now done");
  endtask : t_fire_now

  task automatic t_codes;
    for (int c = 0; c < 15; c++) begin
      io_write(WDT_ENABLE_ADDR, 16'(c) | 16'hfff0);
      chk("steps per code", 16'(15 - c), steps_q);
      chk("armed per code", 16'h1, armed_q);
    end
    io_write(WDT_DISABLE_ADDR, 16'ha5c3);
    chk("armed after disable", 16'h0, armed_q);
    wait_level(1'b1, n);
    chk_in("no reset after disable", 1000, 1000, n);
    $display("test codes done");
  endtask : t_codes

  task automatic t_restart;
    io_write(WDT_ENABLE_ADDR, 16'h000e);
    chk("steps code e", 16'h1, steps_q);
    repeat (5) @(negedge clk);
    io_write(WDT_ENABLE_ADDR, 16'h000d);
    chk("steps after rewrite", 16'h2, steps_q);
    wait_level(1'b1, n);
    chk_in("fire delay 2 steps", (2 * STEP + 2) * 8 / 10,
           (2 * STEP + 2) * 12 / 10, n);
    io_write(WDT_ENABLE_ADDR, 16'h0000);
    wait_level(1'b0, n);
    chk("write while firing", 16'h0, armed_q);
    $display("test restart done");
  endtask : t_restart

  task automatic t_reset_mid;
    io_write(WDT_ENABLE_ADDR, 16'h0000);
    chk("armed before mid reset", 16'h1, armed_q);
    repeat (3) @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk("armed after mid reset", 16'h0, armed_q);
    chk("steps after mid reset", 16'(WDT_STEPS_RST), steps_q);
    wait_level(1'b1, n);
    chk_in("no reset after mid reset", 1000, 1000, n);
    $display("test reset_mid done");
  endtask : t_reset_mid

  task automatic t_ignore;
    io_write(16'h0442, 16'h0000);
    io_write(16'h1443, 16'h0000);
    chk("armed by other address", 16'h0, armed_q);
    io_write(WDT_DISABLE_ADDR, 16'h0000);
    chk("disable while idle", 16'h0, armed_q);
    $display("test ignore done");
  endtask : t_ignore

  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    failures = 0;
    comparisons = 0;
    io = '0;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_fire_now();
    t_codes();
    t_restart();
    t_reset_mid();
    t_ignore();
    report_and_stop();
  end

  initial begin
    #(20000 * 8);
    failures++;
    report_and_stop();
  end
endmodule : tb_top

/* File: common/wdt_pkg.sv */
// constants and types shared by the watchdog timer block
package wdt_pkg;
  // ------------------------------------------------------------------
  // i/o port decode
  // ------------------------------------------------------------------
  localparam logic [15:0] WDT_DISABLE_ADDR = 16'h0441;
  localparam logic [15:0] WDT_ENABLE_ADDR = 16'h0443;
  localparam int WDT_CODE_LSB = 0;
  localparam int WDT_CODE_W = 4;
  localparam logic [3:0] WDT_CODE_MAX = 4'hf;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int WDT_CLK_PERIOD_NS = 8;
  localparam longint WDT_CLK_HZ = 64'd125_000_000;
  localparam longint WDT_STEP_TIME_S = 64'd2;
  localparam int WDT_STEP_CYCLES = int'(WDT_STEP_TIME_S * WDT_CLK_HZ);
  localparam int WDT_TOL_PCT = 20;
  localparam int WDT_RST_PULSE_NS = 1000;
  localparam int WDT_RST_PULSE_CYCLES =
    (WDT_RST_PULSE_NS + WDT_CLK_PERIOD_NS - 1) / WDT_CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // reset values and types
  // ------------------------------------------------------------------
  localparam logic [3:0] WDT_STEPS_RST = 4'h0;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [15:0] data;
  } wdt_io_t;

  typedef enum logic [1:0] {
    WDT_IDLE,
    WDT_ARMED,
    WDT_FIRE
  } wdt_state_t;
endpackage : wdt_pkg

/* File: verilog/wdt_tick.sv */
// step prescaler: one pulse per timeout step while running
`timescale 1ns/1ns
module wdt_tick #(
  parameter int CYCLES = 250_000_000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic restart,
  // step pulse
  output logic tick
);
  import wdt_pkg::*;

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  if (CYCLES < 1) begin : g_bad
    $error("wdt_tick: CYCLES must be at least one");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (restart || !run) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = run && !restart && (cnt_q == LAST);
endmodule : wdt_tick

/* File: verilog/wdt_top.sv */
// watchdog timer behind two write-only i/o ports
`timescale 1ns/1ns
module wdt_top #(
  parameter int STEP_CYCLES = wdt_pkg::WDT_STEP_CYCLES,
  parameter int PULSE_CYCLES = wdt_pkg::WDT_RST_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // i/o write cycle
  input wire wdt_pkg::wdt_io_t io,
  // system reset and status
  output logic sys_reset_q,
  output logic armed_q,
  output logic [3:0] steps_q
);
  import wdt_pkg::*;

  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYCLES - 1);

  if (STEP_CYCLES < 1 || PULSE_CYCLES < 1) begin : g_bad
    $error("wdt_top: STEP_CYCLES and PULSE_CYCLES must be positive");
  end

  // ------------------------------------------------------------------
  // port decode
  // ------------------------------------------------------------------
  logic en_wr;
  logic dis_wr;
  logic [3:0] code;
  logic tick;
  logic fire_go;

  assign en_wr = io.wr && (io.addr == WDT_ENABLE_ADDR);
  assign dis_wr = io.wr && (io.addr == WDT_DISABLE_ADDR);
  assign code = io.data[WDT_CODE_LSB +: WDT_CODE_W];

  // ------------------------------------------------------------------
  // step prescaler
  // ------------------------------------------------------------------
  wdt_state_t state_q;
  wdt_state_t state_d;

  // step length is nominal; the allowed tolerance leaves room to trim it
  wdt_tick #(
    .CYCLES(STEP_CYCLES)
  ) u_tick (
    .clk(clk),
    .rstn(rstn),
    .run(state_q == WDT_ARMED),
    .restart(en_wr),
    .tick(tick)
  );

  // ------------------------------------------------------------------
  // countdown and reset pulse
  // ------------------------------------------------------------------
  logic [3:0] steps_d;
  logic [PW-1:0] pulse_q;
  logic [PW-1:0] pulse_d;
  logic sys_reset_d;
  logic armed_d;

  assign fire_go = (state_q == WDT_ARMED) && !en_wr && !dis_wr &&
                   (steps_q == 4'h0);

  always_comb begin
    state_d = state_q;
    steps_d = steps_q;
    pulse_d = pulse_q;
    sys_reset_d = sys_reset_q;
    unique case (state_q)
      WDT_IDLE: begin
        if (en_wr) begin
          state_d = WDT_ARMED;
          steps_d = WDT_CODE_MAX - code;
        end
      end
      WDT_ARMED: begin
        if (dis_wr) begin
          state_d = WDT_IDLE;
        end else if (en_wr) begin
          steps_d = WDT_CODE_MAX - code;
        end else if (steps_q == 4'h0) begin
          state_d = WDT_FIRE;
          pulse_d = PULSE_LOAD;
          sys_reset_d = 1'b1;
        end else if (tick) begin
          steps_d = steps_q - 4'h1;
        end
      end
      WDT_FIRE: begin
        // writes are ignored while the reset pulse is out
        if (pulse_q == '0) begin
          state_d = WDT_IDLE;
          sys_reset_d = 1'b0;
        end else begin
          pulse_d = pulse_q - PW'(1);
        end
      end
    endcase
    armed_d = (state_d == WDT_ARMED);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= WDT_IDLE;
      steps_q <= WDT_STEPS_RST;
      pulse_q <= '0;
      sys_reset_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      steps_q <= steps_d;
      pulse_q <= pulse_d;
      sys_reset_q <= sys_reset_d;
      armed_q <= armed_d;
    end
  end

  // ------------------------------------------------------------------
  // check helpers
  // ------------------------------------------------------------------
  // cycles armed since the last taken enable write, the step count it
  // chose, and how long the system reset has been out so far
  localparam logic [35:0] STEP_W = 36'(STEP_CYCLES);

  logic [35:0] elapsed_q;
  logic [35:0] elapsed_d;
  logic [3:0] span_q;
  logic [3:0] span_d;
  logic [PW-1:0] high_q;
  logic [PW-1:0] high_d;

  always_comb begin
    elapsed_d = elapsed_q;
    span_d = span_q;
    high_d = '0;
    if (en_wr && state_q != WDT_FIRE) begin
      elapsed_d = '0;
      span_d = WDT_CODE_MAX - code;
    end else if (state_q == WDT_ARMED) begin
      elapsed_d = elapsed_q + 36'h1;
    end
    if (sys_reset_q) begin
      high_d = high_q + PW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      elapsed_q <= '0;
      span_q <= '0;
      high_q <= '0;
    end else begin
      elapsed_q <= elapsed_d;
      span_q <= span_d;
      high_q <= high_d;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_enable_arms: assert property (
    @(posedge clk) disable iff (!rstn)
    en_wr && state_q != WDT_FIRE |=>
      armed_q && steps_q == WDT_CODE_MAX - $past(code))
    else $error("enable write did not arm with the chosen interval");

  a_disable_stops: assert property (
    @(posedge clk) disable iff (!rstn)
    dis_wr && state_q != WDT_FIRE ##1 !en_wr [*4] |->
      !armed_q && !sys_reset_q)
    else $error("disable write left the watchdog running");

  a_idle_quiet: assert property (
    @(posedge clk) disable iff (!rstn)
    state_q == WDT_IDLE && !en_wr |=> !armed_q && !sys_reset_q)
    else $error("idle watchdog armed or fired by itself");

  a_expiry_fires: assert property (
    @(posedge clk) disable iff (!rstn)
    fire_go |=> sys_reset_q && !armed_q)
    else $error("expired watchdog did not reset the system");

  a_reset_cause: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(sys_reset_q) |-> $past(fire_go))
    else $error("system reset without expiry");

  a_no_early_fire: assert property (
    @(posedge clk) disable iff (!rstn)
    state_q == WDT_ARMED && steps_q != 4'h0 |=> !sys_reset_q)
    else $error("system reset before the countdown ran out");

  a_pulse_holds: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(sys_reset_q) |-> sys_reset_q [*8])
    else $error("system reset pulse too short");

  a_pulse_length: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(sys_reset_q) |-> high_q == PW'(PULSE_CYCLES))
    else $error("system reset pulse has the wrong length");

  a_fire_ignores: assert property (
    @(posedge clk) disable iff (!rstn)
    state_q == WDT_FIRE |=> !armed_q)
    else $error("write taken while the reset pulse was out");

  a_code_f_zero: assert property (
    @(posedge clk) disable iff (!rstn)
    en_wr && code == 4'hf && state_q != WDT_FIRE ##1
      !en_wr && !dis_wr |=> sys_reset_q)
    else $error("code f did not expire at once");

  a_step_count: assert property (
    @(posedge clk) disable iff (!rstn)
    tick && state_q == WDT_ARMED && !en_wr && !dis_wr &&
      steps_q != 4'h0 |=> steps_q == $past(steps_q) - 4'h1)
    else $error("countdown did not drop by one step");

  a_interval_len: assert property (
    @(posedge clk) disable iff (!rstn)
    fire_go |-> elapsed_q == STEP_W * 36'(span_q))
    else $error("expiry came after the wrong number of cycles");

  a_rewrite_reload: assert property (
    @(posedge clk) disable iff (!rstn)
    en_wr && state_q == WDT_ARMED |=>
      armed_q && !sys_reset_q &&
      steps_q == WDT_CODE_MAX - $past(code))
    else $error("enable rewrite did not restart the countdown");
endmodule : wdt_top
